// ### inc/ppvp_pkg.sv
package ppvp_pkg;

	// ----------------------------------------------------------------
	// array geometry
	// ----------------------------------------------------------------
	localparam int ppvp_mem_depth = 8064;
	localparam int ppvp_addr_width = 13;
	localparam int ppvp_data_width = 8;
	localparam int ppvp_nibble_width = 4;
	localparam logic [12:0] ppvp_last_addr = 13'h1f7f;
	localparam logic [7:0] ppvp_erased_byte = 8'hff;

	// ----------------------------------------------------------------
	// stepping and buffering
	// ----------------------------------------------------------------
	localparam logic [1:0] ppvp_last_phase = 2'h3;
	localparam int ppvp_fifo_depth = 16;

	// ----------------------------------------------------------------
	// mode pin patterns, bit 0 is the first mode pin
	// ----------------------------------------------------------------
	localparam logic [3:0] ppvp_pat_clear = 4'h5;
	localparam logic [3:0] ppvp_pat_write = 4'he;
	localparam logic [3:0] ppvp_pat_verify = 4'hc;
	localparam logic [3:0] ppvp_pat_inhibit = 4'hd;
	localparam logic [3:0] ppvp_mask_inhibit = 4'hd;

	typedef enum logic [2:0] {
		mode_idle,
		mode_clear,
		mode_write,
		mode_verify,
		mode_inhibit
	} ppvp_mode_type;

	function automatic ppvp_mode_type ppvp_decode(input logic [3:0] pins);
		ppvp_mode_type m;
		m = mode_idle;
		if (pins == ppvp_pat_clear)
			m = mode_clear;
		else if (pins == ppvp_pat_write)
			m = mode_write;
		else if (pins == ppvp_pat_verify)
			m = mode_verify;
		else if ((pins & ppvp_mask_inhibit) == ppvp_pat_inhibit)
			m = mode_inhibit;
		return m;
	endfunction

	function automatic logic [1:0] ppvp_gray2bin(input logic [1:0] g);
		return {g[1], g[1] ^ g[0]};
	endfunction

	function automatic logic [1:0] ppvp_bin2gray(input logic [1:0] b);
		return {b[1], b[1] ^ b[0]};
	endfunction

endpackage

// ### hw/ppvp_fifo.sv
`timescale 1ns/100ps
module ppvp_fifo
#(
	parameter int WIDTH = 21,
	parameter int DEPTH = 16
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);
	localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

	logic [WIDTH-1:0] store [DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [CW-1:0] count;
	logic push;
	logic pop;

	assign in_ready = (count != FULL);
	assign out_valid = (count != '0);
	assign out_data = store[rd_ptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk)
	begin
		if (push)
			store[wr_ptr] <= in_data;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			count <= '0;
		else if (push && !pop)
			count <= count + 1'b1;
		else if (pop && !push)
			count <= count - 1'b1;
	end

endmodule

// ### hw/ppvp_port.sv
// Notes on behaviour
// - address moves only by step clock pulses, apart from reset and clear mode setting it back to 0
// - byte = low nibble group plus high nibble group
// - array holds 8064 bytes, addresses 0 to 1f7f
// - mode pins pick clear, write, verify, inhibit
// - four step pulses advance address by one
// - verify drives byte at current address
`timescale 1ns/100ps
module ppvp_port
(
	input wire logic clk,
	input wire logic rst,
	input wire logic address_step_clock_pin,
	input wire logic inverted_step_clock_pin,
	input wire logic [3:0] program_mode_select_pins,
	input wire logic [ppvp_pkg::ppvp_nibble_width-1:0] data_low_nibble_in,
	output logic [ppvp_pkg::ppvp_nibble_width-1:0] data_low_nibble_out,
	output logic [ppvp_pkg::ppvp_nibble_width-1:0] data_low_nibble_oe,
	input wire logic [ppvp_pkg::ppvp_nibble_width-1:0] data_high_nibble_in,
	output logic [ppvp_pkg::ppvp_nibble_width-1:0] data_high_nibble_out,
	output logic [ppvp_pkg::ppvp_nibble_width-1:0] data_high_nibble_oe,
	output logic [ppvp_pkg::ppvp_addr_width-1:0] prog_address,
	output logic write_busy,
	output logic phase_error
);
	import ppvp_pkg::*;

	localparam int ENTRY_W = ppvp_addr_width + ppvp_data_width;

	// ----------------------------------------------------------------
	// link domain: runs only while the programmer pulses the pin
	// ----------------------------------------------------------------
	// no reset in this domain: the pin need not pulse during reset,
	// so the count starts from its power-up value and the core only
	// ever looks at changes of it
	logic [1:0] link_gray = 2'h0;

	// a gray count lets each pulse cross as one clean bit change
	always_ff @(posedge address_step_clock_pin)
	begin
		link_gray <= ppvp_bin2gray(ppvp_gray2bin(link_gray) + 2'h1);
	end

	// ----------------------------------------------------------------
	// crossings and pin synchronisers on the core clock
	// ----------------------------------------------------------------
	logic [1:0] gray_meta;
	logic [1:0] gray_sync;
	logic [1:0] gray_prev;
	logic step_meta;
	logic step_sync;
	logic inv_meta;
	logic inv_sync;
	logic same_prev;
	logic phase_bad;
	logic [3:0] mode_meta;
	logic [3:0] mode_sync;
	logic [7:0] din_meta;
	logic [7:0] din_sync;

	always_ff @(posedge clk)
	begin
		gray_meta <= link_gray;
		gray_sync <= gray_meta;
		step_meta <= address_step_clock_pin;
		step_sync <= step_meta;
		inv_meta <= inverted_step_clock_pin;
		inv_sync <= inv_meta;
		mode_meta <= program_mode_select_pins;
		mode_sync <= mode_meta;
		din_meta <= {data_high_nibble_in, data_low_nibble_in};
		din_sync <= din_meta;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			gray_prev <= gray_sync;
		else
			gray_prev <= gray_sync;
	end

	// the pins switch together, so equal levels for one cycle can be
	// synchroniser skew; two cycles in a row are a real phase fault
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			same_prev <= 1'b0;
			phase_bad <= 1'b0;
		end
		else
		begin
			same_prev <= (step_sync == inv_sync);
			if (same_prev && step_sync == inv_sync)
				phase_bad <= 1'b1;
		end
	end

	logic pulse;
	assign pulse = (gray_sync != gray_prev);

	// ----------------------------------------------------------------
	// mode decode
	// ----------------------------------------------------------------
	ppvp_mode_type mode;
	ppvp_mode_type mode_prev;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			mode <= mode_idle;
			mode_prev <= mode_idle;
		end
		else
		begin
			mode <= ppvp_decode(mode_sync);
			mode_prev <= mode;
		end
	end

	// ----------------------------------------------------------------
	// address counter
	// ----------------------------------------------------------------
	logic [1:0] phase;
	logic [ppvp_addr_width-1:0] addr;
	logic step;

	assign step = pulse && (phase == ppvp_last_phase);

	always_ff @(posedge clk)
	begin
		if (rst || mode == mode_clear)
			phase <= 2'h0;
		else if (pulse)
			phase <= phase + 2'h1;
	end

	// the counter parks on the last address rather than wrapping
	always_ff @(posedge clk)
	begin
		if (rst || mode == mode_clear)
			addr <= '0;
		else if (step && addr != ppvp_last_addr)
			addr <= addr + 1'b1;
	end

	// ----------------------------------------------------------------
	// write path through the buffer
	// ----------------------------------------------------------------
	logic pend;
	logic [ENTRY_W-1:0] pend_entry;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [ENTRY_W-1:0] fifo_out_data;
	logic drain;
	logic enter_write;

	assign enter_write = (mode == mode_write) && (mode_prev != mode_write);
	// cells are only touched while write is still selected
	assign drain = (mode == mode_write);

	// one entry per write selection; waits while the buffer is full
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pend <= 1'b0;
			pend_entry <= '0;
		end
		else if (enter_write && addr <= ppvp_last_addr)
		begin
			pend <= 1'b1;
			pend_entry <= {addr, din_sync};
		end
		else if (fifo_in_ready)
			pend <= 1'b0;
	end

	ppvp_fifo #(
		.WIDTH(ENTRY_W),
		.DEPTH(ppvp_fifo_depth)
	) u_fifo (
		.clk(clk),
		.rst(rst),
		.in_valid(pend),
		.in_ready(fifo_in_ready),
		.in_data(pend_entry),
		.out_valid(fifo_out_valid),
		.out_ready(drain),
		.out_data(fifo_out_data)
	);

	// ----------------------------------------------------------------
	// cell array
	// ----------------------------------------------------------------
	logic [ppvp_data_width-1:0] cells [ppvp_mem_depth] =
		'{default: ppvp_erased_byte};
	logic mem_we;
	logic [ppvp_addr_width-1:0] we_addr;
	logic [ppvp_data_width-1:0] we_data;
	logic [ppvp_data_width-1:0] rd_byte;

	assign mem_we = fifo_out_valid && drain;
	assign we_addr = fifo_out_data[ENTRY_W-1:ppvp_data_width];
	assign we_data = fifo_out_data[ppvp_data_width-1:0];

	// programming only clears bits, as a real cell can
	always_ff @(posedge clk)
	begin
		if (mem_we)
			cells[we_addr] <= cells[we_addr] & we_data;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			rd_byte <= ppvp_erased_byte;
		else
			rd_byte <= cells[addr];
	end

	// ----------------------------------------------------------------
	// pin outputs
	// ----------------------------------------------------------------
	logic drive;
	assign drive = (mode == mode_verify);

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			data_low_nibble_oe <= '0;
			data_high_nibble_oe <= '0;
		end
		else
		begin
			data_low_nibble_oe <= {ppvp_nibble_width{drive}};
			data_high_nibble_oe <= {ppvp_nibble_width{drive}};
		end
	end

	assign data_low_nibble_out = rd_byte[3:0];
	assign data_high_nibble_out = rd_byte[7:4];

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			prog_address <= '0;
			write_busy <= 1'b0;
			phase_error <= 1'b0;
		end
		else
		begin
			prog_address <= addr;
			write_busy <= pend || fifo_out_valid;
			phase_error <= phase_bad;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_clear_zeroes: assert property (@(posedge clk) disable iff (rst)
		mode == mode_clear |=> addr == '0 && phase == 2'h0)
		else $error("address not cleared in clear mode");

	a_step_four: assert property (@(posedge clk) disable iff (rst)
		mode != mode_clear && step && addr != ppvp_last_addr
		|=> addr == $past(addr) + 1'b1)
		else $error("address did not step after fourth pulse");

	a_no_stray_step: assert property (@(posedge clk) disable iff (rst)
		!step && mode != mode_clear |=> $stable(addr))
		else $error("address moved without a step pulse");

	a_addr_range: assert property (@(posedge clk) disable iff (rst)
		addr <= ppvp_last_addr)
		else $error("address beyond the array");

	a_verify_drive: assert property (@(posedge clk) disable iff (rst)
		mode == mode_verify |=> data_low_nibble_oe == 4'hf
		&& data_high_nibble_oe == 4'hf)
		else $error("data pins not driven in verify");

	a_verify_data: assert property (@(posedge clk) disable iff (rst)
		mode == mode_verify && $past(mode) == mode_verify && $stable(addr)
		|-> {data_high_nibble_out, data_low_nibble_out} == cells[addr])
		else $error("verify byte differs from array");

	a_inhibit_float: assert property (@(posedge clk) disable iff (rst)
		mode == mode_inhibit |=> data_low_nibble_oe == 4'h0
		&& data_high_nibble_oe == 4'h0)
		else $error("data pins driven in inhibit");

	a_inhibit_nowrite: assert property (@(posedge clk) disable iff (rst)
		mode != mode_write |-> !mem_we)
		else $error("cells programmed outside write mode");

	a_phase_flag: assert property (@(posedge clk) disable iff (rst)
		same_prev && step_sync == inv_sync |=> phase_bad)
		else $error("clock phase fault not flagged");

	a_write_queued: assert property (@(posedge clk) disable iff (rst)
		enter_write |=> pend && pend_entry[ppvp_data_width-1:0] == $past(din_sync))
		else $error("write byte not queued");

endmodule

// ### testbench/ppvp_programmer.sv
`timescale 1ns/100ps
module ppvp_programmer
#(
	parameter int write_pulse_cycles = 20
)
(
	input wire logic clk,
	input wire logic [7:0] bus_level,
	output logic step_clk,
	output logic step_clk_n,
	output logic [3:0] mode_pins,
	output logic [7:0] drive_data,
	output logic drive_en
);
	import ppvp_pkg::*;
	// ----------------------------------------------------------------
	// pin state
	// ----------------------------------------------------------------
	logic bad_phase;
	initial
	begin
		step_clk = 1'b0;
		mode_pins = 4'h0;
		drive_data = 8'h00;
		drive_en = 1'b0;
		bad_phase = 1'b0;
	end
	// a fault can be injected to hold the second pin high at a rise
	assign step_clk_n = bad_phase ? 1'b1 : ~step_clk;
	// ----------------------------------------------------------------
	// sequences
	// ----------------------------------------------------------------
	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic set_mode(input logic [3:0] m);
		mode_pins <= m;
		wait_clk(8);
	endtask
	// the step clock stands low between pulses
	task automatic pulses(input int n);
		repeat (n)
		begin
			step_clk <= 1'b1;
			wait_clk(8);
			step_clk <= 1'b0;
			wait_clk(8);
		end
	endtask
	task automatic open_session();
		wait_clk(1000);
		set_mode(ppvp_pat_clear);
		set_mode(ppvp_pat_inhibit);
	endtask
	task automatic close_session();
		set_mode(ppvp_pat_inhibit);
		set_mode(ppvp_pat_clear);
	endtask
	task automatic program_byte(input logic [7:0] b, output int tries);
		tries = 0;
		drive_data <= b;
		do
		begin
			drive_en <= 1'b1;
			mode_pins <= ppvp_pat_write;
			wait_clk(write_pulse_cycles);
			set_mode(ppvp_pat_inhibit);
			drive_en <= 1'b0;
			set_mode(ppvp_pat_verify);
			tries++;
		end
		while (bus_level !== b && tries < 25);
		set_mode(ppvp_pat_inhibit);
		drive_en <= 1'b1;
		mode_pins <= ppvp_pat_write;
		wait_clk(tries * write_pulse_cycles);
		set_mode(ppvp_pat_inhibit);
		drive_en <= 1'b0;
	endtask
endmodule

// ### testbench/prom_program_verify_port_test.sv
`timescale 1ns/100ps
module prom_program_verify_port_test;
	import ppvp_pkg::*;
	typedef struct packed {
		logic [7:0] wdata;
		logic [7:0] expect_byte;
	} ppvp_row_type;
	ppvp_row_type rows [4] = '{16'ha5a5, 16'h3c3c, 16'h0000, 16'hffff};
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic step_clk, step_clk_n, drive_en, write_busy, phase_error;
	logic [3:0] mode_pins, lo_out, lo_oe, hi_out, hi_oe;
	logic [7:0] drive_data, bus_level, dev_oe, dut_data;
	logic [12:0] prog_address;
	int n_errors = 0;
	int cmp_count = 0;
	int tries;
	always #5 clk = ~clk;
	assign dev_oe = {hi_oe, lo_oe};
	assign dut_data = {hi_out, lo_out};
	// open drain lines with pull-downs: released lines read low
	assign bus_level = (dev_oe & dut_data) | (~dev_oe & {8{drive_en}} & drive_data);
	ppvp_programmer prog_u (.clk(clk), .bus_level(bus_level),
		.step_clk(step_clk), .step_clk_n(step_clk_n), .mode_pins(mode_pins),
		.drive_data(drive_data), .drive_en(drive_en));
	ppvp_port dut_u (.clk(clk), .rst(rst), .address_step_clock_pin(step_clk),
		.inverted_step_clock_pin(step_clk_n),
		.program_mode_select_pins(mode_pins),
		.data_low_nibble_in(bus_level[3:0]), .data_low_nibble_out(lo_out),
		.data_low_nibble_oe(lo_oe), .data_high_nibble_in(bus_level[7:4]),
		.data_high_nibble_out(hi_out), .data_high_nibble_oe(hi_oe),
		.prog_address(prog_address), .write_busy(write_busy),
		.phase_error(phase_error));
	// ----------------------------------------------------------------
	// checking and closing
	// ----------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		cmp_count++;
		if (seen !== want)
		begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic wrap_up();
		if (n_errors == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		repeat (40000) @(posedge clk);
		n_errors++;
		wrap_up();
	end
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		check(dev_oe, 8'h00);
		check(dut_data, ppvp_erased_byte);
		check(prog_address, 13'h0000);
		check({write_busy, phase_error}, 2'h0);
		prog_u.open_session();
		for (int i = 0; i < 4; i++)
		begin
			check(prog_address, 13'(i));
			prog_u.program_byte(rows[i].wdata, tries);
			check(16'(tries), 16'h0001);
			prog_u.pulses(4);
		end
		prog_u.set_mode(ppvp_pat_clear);
		prog_u.set_mode(ppvp_pat_verify);
		for (int i = 0; i < 4; i++)
		begin
			check(dev_oe, 8'hff);
			check(bus_level, rows[i].expect_byte);
			prog_u.pulses(4);
		end
		check(prog_address, 13'h0004);
		for (int i = 0; i < 2; i++)
		begin
			prog_u.set_mode(ppvp_pat_inhibit | 4'(i << 1));
			check(dev_oe, 8'h00);
		end
		prog_u.set_mode(ppvp_pat_clear);
		check(prog_address, 13'h0000);
		// data presented under inhibit must not reach the cells
		prog_u.set_mode(ppvp_pat_inhibit);
		prog_u.drive_data <= 8'h00;
		prog_u.drive_en <= 1'b1;
		prog_u.wait_clk(20);
		check(write_busy, 1'b0);
		prog_u.drive_en <= 1'b0;
		prog_u.set_mode(ppvp_pat_verify);
		check(bus_level, rows[0].expect_byte);
		// clear drops a part-counted step and ignores pulses
		prog_u.set_mode(ppvp_pat_inhibit);
		prog_u.pulses(2);
		prog_u.set_mode(ppvp_pat_clear);
		prog_u.pulses(4);
		check(prog_address, 13'h0000);
		prog_u.set_mode(ppvp_pat_inhibit);
		prog_u.pulses(3);
		check(prog_address, 13'h0000);
		prog_u.pulses(1);
		check(prog_address, 13'h0001);
		prog_u.bad_phase <= 1'b1;
		prog_u.pulses(1);
		prog_u.bad_phase <= 1'b0;
		check(phase_error, 1'b1);
		rst <= 1'b1;
		prog_u.pulses(3);
		rst <= 1'b0;
		@(posedge clk);
		check(phase_error, 1'b0);
		// pulses seen during reset must not be counted
		prog_u.pulses(4);
		check(prog_address, 13'h0001);
		prog_u.close_session();
		check(prog_address, 13'h0000);
		wrap_up();
	end
endmodule
